// *** common/jss_defs.svh ***
`ifndef JSS_DEFS_SVH
`define JSS_DEFS_SVH
// Control tick period in microseconds and derived clock count at 25 MHz
`define JSS_CLK_MHZ       25
`define JSS_TICK_US       2000
`define JSS_TICK_CYCLES   (`JSS_TICK_US * `JSS_CLK_MHZ)
// Preset constant speed numbers used by jogging
`define JSS_JOG_PRESET_A  3'h7
`define JSS_JOG_PRESET_B  3'h6
`define JSS_JOG_RAMP_PAIR 2'h2
`define JSS_SPEED_W       16
`endif

// *** common/jss_pkg.sv ***
package jss_pkg;
  typedef enum logic [1:0] {JSS_IDLE, JSS_JOG, JSS_NORMAL} jss_mode_t;
  typedef struct packed {
    logic [15:0] accelTime;
    logic [15:0] decelTime;
  } jss_ramp_t;
  typedef struct packed {
    logic        jogButton;
    logic        busJog1;
    logic        busJog2;
    logic        startCmd;
  } jss_cmd_t;
  typedef struct packed {
    jss_mode_t   mode;
    logic [15:0] tickCnt;
    logic [15:0] speed;
    logic [15:0] rampCnt;
    logic [1:0]  busJogStat;
  } jss_state_t;
endpackage : jss_pkg

// *** hdl/jss_jog_sequencer.sv ***
`include "jss_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module jss_jog_sequencer #(
  parameter int TICK_CYCLES = `JSS_TICK_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clkEn,
  input  wire jss_pkg::jss_cmd_t cmd,
  input  wire logic [15:0]       normalRef,
  input  wire logic [15:0]       constSpeed7,
  input  wire logic [15:0]       constSpeed6,
  input  wire logic              constSpeedSel,
  input  wire logic [15:0]       constSpeedRef,
  input  wire jss_pkg::jss_ramp_t activeRamp,
  input  wire jss_pkg::jss_ramp_t jogRamp,
  input  wire logic [15:0]       activeShape,
  input  wire logic              freewheelStopCfg,
  input  wire logic              relayJogCfg,
  input  wire logic              dOutJogCfg,
  output logic [15:0]            speedRef,
  output logic [15:0]            rampShape,
  output logic [1:0]             rampPairSel,
  output logic                   freewheelStop,
  output logic                   jogActive,
  output logic                   relay_output,
  output logic                   digitalOutput,
  output logic [1:0]             busJogStatus
);
  import jss_pkg::*;

  jss_state_t stateReg;
  jss_state_t stateNext;
  logic       tick;
  logic       jogReq;
  logic [15:0] jogSpeed;
  logic [15:0] target;
  logic [15:0] stepTime;

  function automatic logic [15:0] stepToward(input logic [15:0] cur, input logic [15:0] tgt);
    if (cur < tgt)
      stepToward = cur + 16'h1;
    else if (cur > tgt)
      stepToward = cur - 16'h1;
    else
      stepToward = cur;
  endfunction : stepToward

  // ==========================================================
  // Request decode
  always_comb
  begin
    jogReq = cmd.jogButton | cmd.busJog1 | cmd.busJog2;
    // bus jog presets, jog 1 priority
    if (cmd.jogButton || cmd.busJog1)
      jogSpeed = constSpeed7;
    else
      jogSpeed = constSpeed6;
  end

  // ==========================================================
  // Sequencer
  always_comb
  begin
    stateNext = stateReg;
    tick = (stateReg.tickCnt == 16'(TICK_CYCLES - 1));
    target = 16'h0;
    stepTime = activeRamp.accelTime;
    stateNext.tickCnt = tick ? 16'h0 : stateReg.tickCnt + 16'h1;
    if (tick)
    begin
      if (cmd.startCmd)
        stateNext.mode = JSS_NORMAL;
      else if (jogReq)
        stateNext.mode = JSS_JOG;
      else if (stateReg.speed == 16'h0)
        stateNext.mode = JSS_IDLE;
      stateNext.busJogStat = {cmd.busJog2, cmd.busJog1};
      // Ramp direction picks accel or decel time; a jog stop uses jog ramps
      // Target follows the commands, not the mode: the mode lingers through
      // a ramp-down so that a stop keeps the ramp of the run that it ends
      if (cmd.startCmd)
        target = constSpeedSel ? constSpeedRef : normalRef;
      else if (jogReq)
        target = jogSpeed;
      else
        target = 16'h0;
      // separate jog accel and decel times
      if (stateNext.mode == JSS_JOG || (stateReg.mode == JSS_JOG && !cmd.startCmd))
        stepTime = (target > stateReg.speed) ? jogRamp.accelTime : jogRamp.decelTime;
      else
        stepTime = (target > stateReg.speed) ? activeRamp.accelTime : activeRamp.decelTime;
      // One speed unit per stepTime+1 ticks keeps the ramp linear
      if (stateReg.rampCnt >= stepTime)
      begin
        stateNext.rampCnt = 16'h0;
        stateNext.speed = stepToward(stateReg.speed, target);
      end
      else
        stateNext.rampCnt = stateReg.rampCnt + 16'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      stateReg <= '{mode: JSS_IDLE, tickCnt: 16'h0, speed: 16'h0, rampCnt: 16'h0,
                    busJogStat: 2'h0};
    else if (clkEn)
      stateReg <= stateNext;
  end

  // ==========================================================
  // Outputs
  always_comb
  begin
    jogActive = (stateReg.mode == JSS_JOG);
    speedRef = stateReg.speed;
    rampShape = jogActive ? 16'h0 : activeShape;
    rampPairSel = jogActive ? `JSS_JOG_RAMP_PAIR : 2'h1;
    freewheelStop = freewheelStopCfg & (stateReg.mode == JSS_IDLE);
    relay_output = relayJogCfg & jogActive;
    digitalOutput = dOutJogCfg & jogActive;
    busJogStatus = stateReg.busJogStat;
  end

  // ==========================================================
  // Checks

  // An evaluation edge: the tick counter wraps while the clock is enabled
  sequence s_tick_eval;
    tick && clkEn;
  endsequence

  // Both bus jog requests present with no start command
  sequence s_both_bus;
    !cmd.startCmd && cmd.busJog1 && cmd.busJog2;
  endsequence

  // Start command present at an evaluation edge
  sequence s_start_eval;
    tick && clkEn && cmd.startCmd;
  endsequence

  a_jog_shape_zero: assert property (@(posedge sys_clk) disable iff (rst)
    jogActive |-> rampShape == 16'h0)
    else $error("Shape not zero in jog");

  a_start_overrides: assert property (@(posedge sys_clk) disable iff (rst)
    s_start_eval |=> !jogActive)
    else $error("Jog active under start");

  a_relay_jog: assert property (@(posedge sys_clk) disable iff (rst)
    relay_output == (relayJogCfg && jogActive))
    else $error("Relay mismatch");

  a_digital_jog: assert property (@(posedge sys_clk) disable iff (rst)
    digitalOutput == (dOutJogCfg && jogActive))
    else $error("Digital output mismatch");

  a_no_freewheel: assert property (@(posedge sys_clk) disable iff (rst)
    jogActive |-> !freewheelStop)
    else $error("Freewheel during jog");

  a_jog_pair_sel: assert property (@(posedge sys_clk) disable iff (rst)
    jogActive |-> rampPairSel == `JSS_JOG_RAMP_PAIR)
    else $error("Wrong ramp pair in jog");

  // speed moves only on tick
  // Holding between ticks is what keeps the ramp rate tied to the tick period
  a_speed_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(tick && clkEn) |=> $stable(speedRef))
    else $error("Speed moved between ticks");

  a_status_sample: assert property (@(posedge sys_clk) disable iff (rst)
    s_tick_eval |=> busJogStatus == $past({cmd.busJog2, cmd.busJog1}))
    else $error("Bus jog status not sampled");

  a_both_jogs: assert property (@(posedge sys_clk) disable iff (rst)
    s_tick_eval ##0 s_both_bus |=> jogActive)
    else $error("Both bus jogs did not jog");

  a_idle_stopped: assert property (@(posedge sys_clk) disable iff (rst)
    (stateReg.mode == JSS_IDLE) |-> speedRef == 16'h0)
    else $error("Idle with nonzero speed");

endmodule : jss_jog_sequencer
`default_nettype wire

// *** test/jss_cmd_src.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Button, start source and bus master
module jss_cmd_src (
  input  wire logic         sys_clk,
  input  wire logic [3:0]   req,
  output jss_pkg::jss_cmd_t cmd
);
  import jss_pkg::*;
  // Levels move only at the clock edge
  always_ff @(posedge sys_clk)
    cmd <= req;
endmodule : jss_cmd_src
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import jss_pkg::*;
  logic sys_clk = 0, rst = 1, clkEn = 1;
  logic [3:0] req = 4'h0;
  jss_cmd_t cmd;
  jss_ramp_t actR = '{16'h0, 16'h1}, jogR = '{16'h0, 16'h0};
  logic [15:0] speedRef, rampShape;
  logic [1:0] pairSel, busStat;
  logic fws, jogActive, relayOut, dOut;
  logic constSel = 1, fwsCfg = 1, relayCfg = 1, dOutCfg = 1;
  logic [15:0] shape = 16'h7, held;
  int num_errors = 0, n_tests = 0;
  jss_cmd_src SRC (.sys_clk(sys_clk), .req(req), .cmd(cmd));
  jss_jog_sequencer #(.TICK_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .cmd(cmd), .normalRef(16'h8), .constSpeed7(16'h5), .constSpeed6(16'h3),
    .constSpeedSel(constSel), .constSpeedRef(16'h9), .activeRamp(actR), .jogRamp(jogR),
    .activeShape(shape), .freewheelStopCfg(fwsCfg), .relayJogCfg(relayCfg),
    .dOutJogCfg(dOutCfg),
    .speedRef(speedRef), .rampShape(rampShape), .rampPairSel(pairSel),
    .freewheelStop(fws), .jogActive(jogActive), .relay_output(relayOut),
    .digitalOutput(dOut), .busJogStatus(busStat));
  // ==========
  // Clock and helpers
  initial forever #20 sys_clk = ~sys_clk;
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task go(input logic [3:0] r, input int n);
    @(posedge sys_clk);
    req <= r;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : go
  task summarize;
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // ==========
  // Watchdog, well past the expected run
  initial
  begin
    #400000;
    num_errors++;
    summarize();
  end
  // ==========
  // Scenarios; slow normal decel keeps ramp-down visible
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    go(4'h8, 80);
    check(speedRef, 16'h5);
    check(rampShape, 16'h0);
    check(16'(pairSel), 16'h2);
    check(16'({jogActive, relayOut, dOut}), 16'h7);
    go(4'h0, 9);
    check(16'(fws), 16'h0);
    @(posedge sys_clk) clkEn <= 1'b0;
    #1 held = speedRef;
    go(4'h0, 20);
    check(speedRef, held);
    @(posedge sys_clk) clkEn <= 1'b1;
    go(4'h0, 72);
    check(speedRef, 16'h0);
    @(posedge sys_clk) constSel <= 1'b0;
    go(4'h9, 80);
    check(speedRef, 16'h8);
    check(16'({jogActive, pairSel}), 16'h1);
    check(rampShape, 16'h7);
    go(4'h8, 80);
    check(speedRef, 16'h5);
    check(16'(pairSel), 16'h2);
    @(posedge sys_clk) relayCfg <= 1'b0;
    go(4'h2, 80);
    check(speedRef, 16'h3);
    check(16'({jogActive, relayOut, dOut}), 16'h5);
    check(16'(busStat), 16'h2);
    go(4'h6, 80);
    check(speedRef, 16'h5);
    check(16'(busStat), 16'h3);
    @(posedge sys_clk) constSel <= 1'b1;
    go(4'h1, 80);
    check(speedRef, 16'h9);
    go(4'h0, 12);
    check(16'(pairSel), 16'h1);
    check(16'(speedRef > 16'h0), 16'h1);
    go(4'h0, 100);
    check(speedRef, 16'h0);
    check(16'(fws), 16'h1);
    summarize();
  end
endmodule : tb
`default_nettype wire
